// File: src/drive_word_pkg.sv
// Constants for the drive command and state word interpreter
// =====================================================================
// Function
// - Bits 0-1 pick one of four presets
// - Bit 2 low applies DC braking
// - Bit 3 low coasts, output stage off
// - Bit 4 low performs quick stop
// - Bit 5 low freezes output frequency
// - Frozen drive stops only by coast/brake
// - Bit 6 low ramps to standstill
// - Trip reset on rising edge of bit 7
// - Bit 8 high selects jog speed
// - Bit 9 selects ramp set two
// - Words with bit 10 low are ignored
// - Bits 11/12 drive relays when configured
// - Bits 13/14 select setup in multi-setup
// - Bit 15 reverses if direction permits
// - Coast, start, setup and preset bits gate with digital inputs
// - State bits 0-2 show readiness
// - Bits 3,4,6,7 show trip/error/warning
// - State bit 5 reserved, reads zero
// - Bit 8 shows speed equals reference
// - Bit 9 shows bus control possible
// - Bits 10,11 show limits and operation
// - Bits 12-15 show brake, voltage, torque, timer
package drive_word_pkg;
  // =====================================================================
  // Command word bit positions
  localparam int unsigned CMD_PRESET_LSB = 0;
  localparam int unsigned CMD_PRESET_MSB = 1;
  localparam int unsigned CMD_RAMP_ENABLE = 2;
  localparam int unsigned CMD_NO_COAST = 3;
  localparam int unsigned CMD_NO_QSTOP = 4;
  localparam int unsigned CMD_USE_RAMP = 5;
  localparam int unsigned CMD_START = 6;
  localparam int unsigned CMD_RESET = 7;
  localparam int unsigned CMD_JOG = 8;
  localparam int unsigned CMD_RAMP2 = 9;
  localparam int unsigned CMD_VALID = 10;
  localparam int unsigned CMD_RELAY1 = 11;
  localparam int unsigned CMD_RELAY4 = 12;
  localparam int unsigned CMD_SETUP_LSB = 13;
  localparam int unsigned CMD_SETUP_MSB = 14;
  localparam int unsigned CMD_REVERSE = 15;
  // =====================================================================
  // Configuration codes
  localparam logic [7:0] RELAY1_FUNC_CODE = 8'h24;
  localparam logic [7:0] RELAY4_FUNC_CODE = 8'h25;
  localparam logic [3:0] MULTI_SETUP_CODE = 4'h9;
  // Command word value after reset: all stop requests active
  localparam logic [15:0] CMD_RESET_VALUE = 16'h0000;
  // Gating selection per function
  typedef enum logic [1:0] {
    GATE_INPUT = 2'h0, GATE_BUS = 2'h1, GATE_AND = 2'h2, GATE_OR = 2'h3
  } gate_type;
  localparam int unsigned NUM_GATES = 4;
  localparam int unsigned GATE_COAST = 0;
  localparam int unsigned GATE_START = 1;
  localparam int unsigned GATE_SETUP = 2;
  localparam int unsigned GATE_PRESET = 3;
  // =====================================================================
  // State word bit positions
  localparam int unsigned ST_CTRL_READY = 0;
  localparam int unsigned ST_DRIVE_READY = 1;
  localparam int unsigned ST_ENABLE = 2;
  localparam int unsigned ST_TRIP = 3;
  localparam int unsigned ST_ERROR = 4;
  localparam int unsigned ST_RESERVED = 5;
  localparam int unsigned ST_TRIP_LOCK = 6;
  localparam int unsigned ST_WARNING = 7;
  localparam int unsigned ST_SPEED_EQ = 8;
  localparam int unsigned ST_BUS_CTRL = 9;
  localparam int unsigned ST_FREQ_OK = 10;
  localparam int unsigned ST_RUNNING = 11;
  localparam int unsigned ST_BRAKE_FAULT = 12;
  localparam int unsigned ST_VOLTAGE = 13;
  localparam int unsigned ST_TORQUE = 14;
  localparam int unsigned ST_TIMER = 15;
endpackage : drive_word_pkg

// File: src/gate_if.sv
// Interface carrying bus and input bits into the gating combiner
`timescale 1ns/1ps
interface gate_if;
  import drive_word_pkg::*;
  logic [NUM_GATES-1:0] bus_bit;
  logic [NUM_GATES-1:0] din_bit;
  logic [2*NUM_GATES-1:0] sel;
  logic [NUM_GATES-1:0] result;
  modport owner (output bus_bit, output din_bit, output sel, input result);
  modport combiner (input bus_bit, input din_bit, input sel, output result);
endinterface : gate_if

// File: src/bit_gate.sv
// Per-function combiner of a bus bit with a digital-input bit
`timescale 1ns/1ps
module bit_gate
  import drive_word_pkg::*;
(
  gate_if.combiner g
);
  // =====================================================================
  // One combiner per gated function
  for (genvar i = 0; i < NUM_GATES; i++) begin : g_gate
    wire [1:0] s = g.sel[2*i+1:2*i];
    assign g.result[i] = (s == GATE_INPUT) ? g.din_bit[i] :
                         (s == GATE_BUS) ? g.bus_bit[i] :
                         (s == GATE_AND) ? (g.bus_bit[i] & g.din_bit[i]) :
                         (g.bus_bit[i] | g.din_bit[i]);
  end
endmodule : bit_gate

// File: src/drive_word_ctrl.sv
// Drive command word interpreter and state word assembler
`timescale 1ns/1ps
module drive_word_ctrl
  import drive_word_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Command word from the network controller
  input wire logic [15:0] drive_command_word_i,
  input wire logic cmd_strobe_i,
  // State word to the network controller
  input wire logic state_req_i,
  output logic [15:0] drive_state_word_o,
  output logic state_valid_o,
  // Configuration
  input wire logic [7:0] relay1_func_i,
  input wire logic [7:0] relay4_func_i,
  input wire logic [3:0] active_setup_cfg_i,
  input wire logic reverse_permit_i,
  input wire logic [7:0] gate_sel_i,
  // Digital-input functions, one per gated function, and freeze-time stops
  input wire logic [3:0] din_func_i,
  input wire logic din_setup_msb_i,
  input wire logic din_preset_msb_i,
  input wire logic din_stop_i,
  // Drive conditions
  input wire logic tripped_i,
  input wire logic trip_locked_i,
  input wire logic error_i,
  input wire logic warning_i,
  input wire logic power_ready_i,
  input wire logic speed_match_i,
  input wire logic local_ctrl_i,
  input wire logic freq_in_limits_i,
  input wire logic freq_nonzero_i,
  input wire logic brake_fault_i,
  input wire logic dc_volt_fault_i,
  input wire logic torque_limit_i,
  input wire logic thermal_over_i,
  // Drive actions
  output logic [1:0] preset_sel_o,
  output logic dc_brake_o,
  output logic coast_o,
  output logic quick_stop_o,
  output logic freq_hold_o,
  output logic ramp_stop_o,
  output logic trip_reset_o,
  output logic jog_o,
  output logic ramp_set2_o,
  output logic relay1_o,
  output logic relay4_o,
  output logic [1:0] setup_sel_o,
  output logic reverse_o
);
  // =====================================================================
  // Accepted command word
  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  logic reset_bit_q;
  logic [15:0] state_q;
  logic state_valid_q;
  wire take_word = cmd_strobe_i && drive_command_word_i[CMD_VALID];
  assign cmd_d = take_word ? drive_command_word_i : cmd_q;
  // Reset-edge uses the accepted words only, so an ignored word cannot fire it
  wire reset_edge = take_word && drive_command_word_i[CMD_RESET] && !reset_bit_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q <= CMD_RESET_VALUE;
      reset_bit_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      if (take_word) begin
        reset_bit_q <= drive_command_word_i[CMD_RESET];
      end
    end
  end
  // =====================================================================
  // Gating with digital inputs
  gate_if gi();
  assign gi.bus_bit = {cmd_q[CMD_PRESET_MSB], cmd_q[CMD_SETUP_MSB],
                       cmd_q[CMD_START], cmd_q[CMD_NO_COAST]};
  assign gi.din_bit = din_func_i;
  assign gi.sel = gate_sel_i;
  bit_gate u_gate (
    .g(gi)
  );
  wire no_coast_g = gi.result[GATE_COAST];
  wire start_g = gi.result[GATE_START];
  wire setup_msb_g = gi.result[GATE_SETUP];
  wire preset_msb_g = gi.result[GATE_PRESET];
  // Setup and preset LSBs use the same selection as their MSBs
  wire [1:0] setup_s = gate_sel_i[2*GATE_SETUP+1:2*GATE_SETUP];
  wire [1:0] preset_s = gate_sel_i[2*GATE_PRESET+1:2*GATE_PRESET];
  wire setup_lsb_g = (setup_s == GATE_INPUT) ? din_setup_msb_i :
                     (setup_s == GATE_BUS) ? cmd_q[CMD_SETUP_LSB] :
                     (setup_s == GATE_AND) ? (cmd_q[CMD_SETUP_LSB] & din_setup_msb_i) :
                     (cmd_q[CMD_SETUP_LSB] | din_setup_msb_i);
  wire preset_lsb_g = (preset_s == GATE_INPUT) ? din_preset_msb_i :
                      (preset_s == GATE_BUS) ? cmd_q[CMD_PRESET_LSB] :
                      (preset_s == GATE_AND) ? (cmd_q[CMD_PRESET_LSB] & din_preset_msb_i) :
                      (cmd_q[CMD_PRESET_LSB] | din_preset_msb_i);
  // =====================================================================
  // Action decode
  wire hold = !cmd_q[CMD_USE_RAMP];
  wire coast_act = !no_coast_g || (hold && din_stop_i);
  wire brake_act = !cmd_q[CMD_RAMP_ENABLE];
  // While frozen, ramp and quick stops are not honoured
  wire qstop_act = !hold && !cmd_q[CMD_NO_QSTOP];
  wire rstop_act = !hold && !start_g;
  wire multi_setup = active_setup_cfg_i == MULTI_SETUP_CODE;
  logic [1:0] setup_q;
  logic trip_reset_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      setup_q <= 2'h0;
      trip_reset_q <= 1'b0;
    end else begin
      trip_reset_q <= reset_edge;
      if (multi_setup) begin
        setup_q <= {setup_msb_g, setup_lsb_g};
      end
    end
  end
  assign preset_sel_o = {preset_msb_g, preset_lsb_g};
  assign dc_brake_o = brake_act;
  assign coast_o = coast_act;
  assign quick_stop_o = qstop_act;
  assign freq_hold_o = hold;
  assign ramp_stop_o = rstop_act;
  assign trip_reset_o = trip_reset_q;
  assign jog_o = cmd_q[CMD_JOG];
  assign ramp_set2_o = cmd_q[CMD_RAMP2];
  assign relay1_o = cmd_q[CMD_RELAY1] && (relay1_func_i == RELAY1_FUNC_CODE);
  assign relay4_o = cmd_q[CMD_RELAY4] && (relay4_func_i == RELAY4_FUNC_CODE);
  assign setup_sel_o = setup_q;
  assign reverse_o = cmd_q[CMD_REVERSE] && reverse_permit_i;
  // =====================================================================
  // State word assembly
  logic [15:0] state_d;
  always_comb begin
    state_d = 16'h0000;
    state_d[ST_CTRL_READY] = !tripped_i && !trip_locked_i;
    state_d[ST_DRIVE_READY] = power_ready_i && !tripped_i && !trip_locked_i;
    state_d[ST_ENABLE] = !coast_act;
    state_d[ST_TRIP] = tripped_i;
    state_d[ST_ERROR] = error_i && !tripped_i;
    state_d[ST_RESERVED] = 1'b0;
    state_d[ST_TRIP_LOCK] = trip_locked_i;
    state_d[ST_WARNING] = warning_i;
    state_d[ST_SPEED_EQ] = speed_match_i;
    state_d[ST_BUS_CTRL] = !local_ctrl_i;
    state_d[ST_FREQ_OK] = freq_in_limits_i;
    state_d[ST_RUNNING] = (start_g && !hold) || freq_nonzero_i;
    state_d[ST_BRAKE_FAULT] = brake_fault_i;
    state_d[ST_VOLTAGE] = dc_volt_fault_i;
    state_d[ST_TORQUE] = torque_limit_i;
    state_d[ST_TIMER] = thermal_over_i;
  end
  // Word is captured on each request and held until the next, so it shows the state at the last request
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= 16'h0000;
      state_valid_q <= 1'b0;
    end else begin
      state_valid_q <= state_req_i;
      if (state_req_i) begin
        state_q <= state_d;
      end
    end
  end
  assign drive_state_word_o = state_q;
  assign state_valid_o = state_valid_q;
  // =====================================================================
  // Checks
  ignore_word_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_strobe_i && !drive_command_word_i[CMD_VALID] |=> $stable(cmd_q))
    else $error("invalid word changed the command");
  reset_edge_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    trip_reset_o |=> !trip_reset_o)
    else $error("trip reset held longer than one cycle");
  reset_cause_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    take_word && drive_command_word_i[CMD_RESET] && !reset_bit_q |=> trip_reset_o)
    else $error("rising reset bit gave no reset");
  relay_cfg_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    relay1_o |-> relay1_func_i == RELAY1_FUNC_CODE)
    else $error("relay one on without configuration");
  reserved_bit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !drive_state_word_o[ST_RESERVED])
    else $error("reserved state bit set");
  state_fresh_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_req_i |=> state_valid_o && drive_state_word_o[ST_TRIP] == $past(tripped_i))
    else $error("state word not refreshed");
  reverse_perm_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    reverse_o |-> reverse_permit_i)
    else $error("reverse without permission");
  setup_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !multi_setup |=> $stable(setup_sel_o))
    else $error("setup changed outside multi-setup");
  freeze_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    freq_hold_o |-> !quick_stop_o && !ramp_stop_o)
    else $error("ramp stop while frozen");
  // =====================================================================
  // Output checks: an accepted word shows one cycle later (setup select two cycles later), others leave actions alone
  wire [1:0] coast_s = gate_sel_i[2*GATE_COAST+1:2*GATE_COAST];
  wire [1:0] start_s = gate_sel_i[2*GATE_START+1:2*GATE_START];

  preset_bus_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_word |=> preset_s != GATE_BUS ||
      preset_sel_o == $past(drive_command_word_i[CMD_PRESET_MSB:CMD_PRESET_LSB]))
    else $error("preset select did not follow the word");

  preset_input_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    preset_s == GATE_INPUT |-> preset_sel_o == {din_func_i[GATE_PRESET], din_preset_msb_i})
    else $error("preset select ignored the digital inputs");

  brake_take_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_word |=> dc_brake_o == !$past(drive_command_word_i[CMD_RAMP_ENABLE]))
    else $error("brake output did not follow the word");

  brake_keep_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !take_word |=> $stable(dc_brake_o))
    else $error("brake output changed without a word");

  coast_take_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_word |=> coast_s != GATE_BUS || coast_o ==
      (!$past(drive_command_word_i[CMD_NO_COAST]) || (freq_hold_o && din_stop_i)))
    else $error("coast output did not follow the word");

  qstop_take_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_word |=> quick_stop_o == (!$past(drive_command_word_i[CMD_NO_QSTOP]) &&
      $past(drive_command_word_i[CMD_USE_RAMP])))
    else $error("quick stop did not follow the word");

  hold_take_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_word |=> freq_hold_o == !$past(drive_command_word_i[CMD_USE_RAMP]))
    else $error("frequency hold did not follow the word");

  hold_keep_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !take_word |=> $stable(freq_hold_o))
    else $error("frequency hold changed without a word");

  freeze_coast_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    freq_hold_o && din_stop_i |-> coast_o)
    else $error("input stop ignored while frozen");

  rstop_take_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_word |=> start_s != GATE_BUS || ramp_stop_o ==
      (!$past(drive_command_word_i[CMD_START]) && $past(drive_command_word_i[CMD_USE_RAMP])))
    else $error("ramp stop did not follow the word");

  reset_quiet_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !reset_edge |=> !trip_reset_o)
    else $error("trip reset without a rising reset bit");

  jog_take_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_word |=> jog_o == $past(drive_command_word_i[CMD_JOG]))
    else $error("jog did not follow the word");

  jog_keep_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !take_word |=> $stable(jog_o))
    else $error("jog changed without a word");

  ramp_take_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_word |=> ramp_set2_o == $past(drive_command_word_i[CMD_RAMP2]))
    else $error("ramp set did not follow the word");

  ramp_keep_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !take_word |=> $stable(ramp_set2_o))
    else $error("ramp set changed without a word");

  relay1_take_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_word |=> relay1_o ==
      ($past(drive_command_word_i[CMD_RELAY1]) && relay1_func_i == RELAY1_FUNC_CODE))
    else $error("relay one did not follow the word");

  relay4_take_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_word |=> relay4_o ==
      ($past(drive_command_word_i[CMD_RELAY4]) && relay4_func_i == RELAY4_FUNC_CODE))
    else $error("relay four did not follow the word");

  relay4_cfg_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    relay4_o |-> relay4_func_i == RELAY4_FUNC_CODE)
    else $error("relay four on without configuration");

  reverse_take_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    take_word |=> reverse_o == ($past(drive_command_word_i[CMD_REVERSE]) && reverse_permit_i))
    else $error("reverse did not follow the word");

  setup_bus_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    multi_setup && setup_s == GATE_BUS |=>
      setup_sel_o == $past(cmd_q[CMD_SETUP_MSB:CMD_SETUP_LSB]))
    else $error("setup select did not follow the command");

  valid_pulse_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !state_req_i |=> !state_valid_o)
    else $error("state valid without a request");

  state_keep_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !state_req_i |=> $stable(drive_state_word_o))
    else $error("state word changed without a request");

  ready_bits_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_req_i |=> drive_state_word_o[ST_CTRL_READY] ==
      !($past(tripped_i) || $past(trip_locked_i)))
    else $error("control ready bit wrong");

  enable_bit_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_req_i |=> drive_state_word_o[ST_ENABLE] == !$past(coast_o))
    else $error("enable bit disagrees with coast");

  error_bit_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_req_i |=> drive_state_word_o[ST_ERROR] == ($past(error_i) && !$past(tripped_i)))
    else $error("error bit wrong");

  bus_ctrl_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_req_i |=> drive_state_word_o[ST_BUS_CTRL] == !$past(local_ctrl_i))
    else $error("bus control bit wrong");

  running_bit_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_req_i |=> drive_state_word_o[ST_RUNNING] ==
      ($past(freq_nonzero_i) || ($past(start_g) && !$past(freq_hold_o))))
    else $error("operation bit wrong");

  fault_bits_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_req_i |=> drive_state_word_o[ST_TIMER] == $past(thermal_over_i) &&
      drive_state_word_o[ST_TORQUE] == $past(torque_limit_i))
    else $error("fault bits wrong");
endmodule : drive_word_ctrl

// File: test/net_ctrl_model.sv
// Behavioural network controller that sends command words and reads state words
`timescale 1ns/1ps
module net_ctrl_model (
  // Clock
  input wire logic core_clk_i,
  // Command side
  output logic [15:0] cmd_word_o,
  output logic cmd_strobe_o,
  // State side
  output logic state_req_o,
  input wire logic [15:0] state_word_i,
  input wire logic state_valid_i
);
  initial begin
    cmd_word_o = 16'h0000;
    cmd_strobe_o = 1'b0;
    state_req_o = 1'b0;
  end
  // =====================================================================
  // Requests; idle cycles in front model a slow controller
  task automatic send_word(input logic [15:0] w, input logic apply, input int idle);
    repeat (idle + 1) @(posedge core_clk_i);
    #1;
    cmd_word_o = apply ? w : (w & 16'hfbff);
    cmd_strobe_o = 1'b1;
    @(posedge core_clk_i);
    #1;
    cmd_strobe_o = 1'b0;
    // Lines are not held once the strobe has gone
    cmd_word_o = ~cmd_word_o;
  endtask : send_word
  task automatic read_state(output logic [15:0] w, output logic v);
    @(posedge core_clk_i);
    #1;
    state_req_o = 1'b1;
    @(posedge core_clk_i);
    #1;
    state_req_o = 1'b0;
    w = state_word_i;
    v = state_valid_i;
  endtask : read_state
endmodule : net_ctrl_model

// File: test/test_drive_word_ctrl.sv
// Self-checking bench for the drive command and state word interpreter
`timescale 1ns/1ps
module test_drive_word_ctrl;
  import drive_word_pkg::*;
  logic core_clk_i, rst_n_i, cmd_strobe, state_req, state_valid, permit, din_stop;
  logic din_setup_lsb, din_preset_lsb, dc_brake, coast, quick_stop, freq_hold, ramp_stop;
  logic trip_reset, jog, ramp_set2, relay1, relay4, reverse;
  logic [15:0] cmd_word, state_word, cur;
  logic [7:0] relay1_func, relay4_func, gate_sel;
  logic [3:0] setup_cfg, din_func;
  logic [1:0] preset_sel, setup_sel, exp_setup, pb;
  logic [12:0] cond;
  int fail_count, n_compared;
  wire [11:0] act = {preset_sel, dc_brake, coast, quick_stop, freq_hold, ramp_stop, jog,
                     ramp_set2, relay1, relay4, reverse};
  net_ctrl_model net (.core_clk_i(core_clk_i), .cmd_word_o(cmd_word), .cmd_strobe_o(cmd_strobe),
    .state_req_o(state_req), .state_word_i(state_word), .state_valid_i(state_valid));
  drive_word_ctrl DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .drive_command_word_i(cmd_word), .cmd_strobe_i(cmd_strobe), .state_req_i(state_req),
    .drive_state_word_o(state_word), .state_valid_o(state_valid), .relay1_func_i(relay1_func),
    .relay4_func_i(relay4_func), .active_setup_cfg_i(setup_cfg), .reverse_permit_i(permit),
    .gate_sel_i(gate_sel), .din_func_i(din_func), .din_setup_msb_i(din_setup_lsb),
    .din_preset_msb_i(din_preset_lsb), .din_stop_i(din_stop), .tripped_i(cond[12]),
    .trip_locked_i(cond[11]), .error_i(cond[10]), .warning_i(cond[9]),
    .power_ready_i(cond[8]), .speed_match_i(cond[7]), .local_ctrl_i(cond[6]),
    .freq_in_limits_i(cond[5]), .freq_nonzero_i(cond[4]), .brake_fault_i(cond[3]),
    .dc_volt_fault_i(cond[2]), .torque_limit_i(cond[1]), .thermal_over_i(cond[0]),
    .preset_sel_o(preset_sel), .dc_brake_o(dc_brake), .coast_o(coast),
    .quick_stop_o(quick_stop), .freq_hold_o(freq_hold), .ramp_stop_o(ramp_stop),
    .trip_reset_o(trip_reset), .jog_o(jog), .ramp_set2_o(ramp_set2), .relay1_o(relay1),
    .relay4_o(relay4), .setup_sel_o(setup_sel), .reverse_o(reverse));
  initial begin
    core_clk_i = 1'b0;
    forever begin
      #50 core_clk_i = ~core_clk_i;
    end
  end
  // =====================================================================
  // Expectations
  function automatic logic gt(input logic [1:0] m, input logic b, input logic d);
    return (m == GATE_INPUT) ? d : (m == GATE_BUS) ? b : (m == GATE_AND) ? (b & d) : (b | d);
  endfunction : gt
  function automatic logic [11:0] exp_act(input logic [15:0] w);
    logic h;
    logic nc;
    h = ~w[5];
    // A frozen drive still obeys a stop from the digital inputs
    nc = gt(gate_sel[1:0], w[3], din_func[0]) & ~(din_stop & h);
    return {gt(gate_sel[7:6], w[1], din_func[3]), gt(gate_sel[7:6], w[0], din_preset_lsb),
      ~w[2], ~nc, ~w[4] & ~h, h, ~gt(gate_sel[3:2], w[6], din_func[1]) & ~h, w[8], w[9],
      w[11] & (relay1_func == RELAY1_FUNC_CODE), w[12] & (relay4_func == RELAY4_FUNC_CODE),
      w[15] & permit};
  endfunction : exp_act
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  // =====================================================================
  // Access tasks
  task automatic put(input logic [15:0] w, input logic apply, input int idle);
    logic [15:0] eff;
    logic tr;
    eff = apply ? w : (w & 16'hfbff);
    tr = eff[10] & eff[7] & ~cur[7];
    if (eff[10]) begin
      cur = eff;
      if (setup_cfg == MULTI_SETUP_CODE) begin
        exp_setup = {gt(gate_sel[5:4], eff[14], din_func[2]),
                     gt(gate_sel[5:4], eff[13], din_setup_lsb)};
      end
    end
    net.send_word(w, apply, idle);
    check("trip_reset", tr, trip_reset);
    check("actions", exp_act(cur), act);
    @(posedge core_clk_i);
    #1;
    check("trip_reset", 0, trip_reset);
    check("setup_sel", exp_setup, setup_sel);
  endtask : put
  task automatic get_state(input logic [12:0] c);
    logic [15:0] w;
    logic [15:0] e;
    logic [11:0] a;
    logic v;
    cond = c;
    a = exp_act(cur);
    e = {c[0], c[1], c[2], c[3], ~(a[5] | a[6]) | c[4], c[5], ~c[6], c[7], c[9], c[11], 1'b0,
         c[10] & ~c[12], c[12], ~a[8], c[8] & ~c[12] & ~c[11], ~c[12] & ~c[11]};
    net.read_state(w, v);
    check("state_word", e, w);
    check("state_valid", 1, v);
  endtask : get_state
  initial begin
    fail_count = 0;
    n_compared = 0;
    cur = 16'h0000;
    exp_setup = 2'h0;
    rst_n_i = 1'b0;
    cond = 13'h0000;
    gate_sel = 8'h55;
    din_func = 4'h0;
    din_setup_lsb = 1'b0;
    din_preset_lsb = 1'b0;
    din_stop = 1'b0;
    relay1_func = RELAY1_FUNC_CODE;
    relay4_func = RELAY4_FUNC_CODE;
    setup_cfg = MULTI_SETUP_CODE;
    permit = 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    check("state_word", 16'h0000, state_word);
    check("state_valid", 0, state_valid);
    check("actions", exp_act(16'h0000), act);
    check("setup_sel", 0, setup_sel);
    $display("Test reset done");
    // Four gating modes, relay codes swapped and reversing barred on odd passes
    for (int p = 0; p < 4; p++) begin
      pb = 2'(p);
      gate_sel = {4{pb ^ 2'h1}};
      din_func = pb[0] ? 4'h5 : 4'ha;
      din_setup_lsb = pb[1];
      din_preset_lsb = pb[0];
      din_stop = pb[1];
      relay1_func = pb[0] ? RELAY4_FUNC_CODE : RELAY1_FUNC_CODE;
      relay4_func = pb[0] ? RELAY1_FUNC_CODE : RELAY4_FUNC_CODE;
      permit = ~pb[0];
      setup_cfg = (p == 2) ? 4'h3 : MULTI_SETUP_CODE;
      for (int i = 0; i < 16; i++) begin
        put(16'h0400 | (16'h0001 << i), 1'b1, i % 2);
        put(~(16'h0001 << i), (i % 2) == 1, 0);
      end
    end
    $display("Test command words done");
    gate_sel = 8'h55;
    din_stop = 1'b0;
    for (int j = 0; j < 2; j++) begin
      put((j == 1) ? 16'h047f : 16'h0400, 1'b1, 0);
      for (int k = 0; k < 14; k++) begin
        get_state((k == 13) ? 13'h1fff : (13'h0001 << k));
      end
    end
    @(posedge core_clk_i);
    #1;
    check("state_valid", 0, state_valid);
    $display("Test state words done");
    test_done();
  end
endmodule : test_drive_word_ctrl
